/* common/mem_decode_pkg.sv */
package mem_decode_pkg;

    // ------------------------------------------------------------
    // table geometry
    // ------------------------------------------------------------
    localparam int INDEX_W = 8; // jumpers plus five address lines
    localparam int ENTRY_W = 4; // one nibble per 1K-word block
    localparam int ENTRIES = 256; // full table depth
    localparam int TABLE_W = 1024; // entries times nibble width
    localparam int ADDR_W = 5; // top five address lines
    localparam int MAP_W = 128; // one map of 32 nibbles

    // ------------------------------------------------------------
    // nibble field positions (all active low)
    // ------------------------------------------------------------
    localparam int RAM_BIT = 3; // ram block enable
    localparam int EPROM_B_BIT = 2; // second eprom bank
    localparam int EPROM_A_BIT = 1; // first eprom bank
    localparam int ONBOARD_BIT = 0; // on-board flag

    // ------------------------------------------------------------
    // jumper positions inside the table index
    // ------------------------------------------------------------
    localparam int JMP_PRESENT_POS = 5; // 1: eprom in the map
    localparam int JMP_RAM_HIGH_POS = 6; // 1: ram at the top
    localparam int JMP_SMALL_POS = 7; // 1: small eprom devices

    // ------------------------------------------------------------
    // reset values and clocking
    // ------------------------------------------------------------
    localparam logic SELECT_IDLE = 1'h1; // selects rest inactive
    localparam logic EXTRA_ADDR_IDLE = 1'h0; // extra eprom address bit
    localparam int CLK_PERIOD_NS = 40; // 25 MHz system clock
    localparam int SYNC_STAGES = 2; // flip-flops per pin input

    // ------------------------------------------------------------
    // default maps, entry 0 in the lowest nibble
    // ------------------------------------------------------------
    localparam logic [MAP_W-1:0] MAP_LARGE_LOW_NONE = 128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFF66;
    localparam logic [MAP_W-1:0] MAP_LARGE_LOW_HIGH = 128'hAACCFFFF_FFFFFFFF_FFFFFFFF_FFFFFF66;
    localparam logic [MAP_W-1:0] MAP_LARGE_HIGH_NONE = 128'h66FFFFFF_FFFFFFFF_FFFFFFFF_FFFFFFFF;
    localparam logic [MAP_W-1:0] MAP_LARGE_HIGH_LOW = 128'h66FFFFFF_FFFFFFFF_FFFFFFFF_FFFFAACC;
    localparam logic [MAP_W-1:0] MAP_SMALL_LOW_NONE = 128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFF66;
    localparam logic [MAP_W-1:0] MAP_SMALL_LOW_HIGH = 128'hACFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFF66;
    localparam logic [MAP_W-1:0] MAP_SMALL_HIGH_NONE = 128'h66FFFFFF_FFFFFFFF_FFFFFFFF_FFFFFFFF;
    localparam logic [MAP_W-1:0] MAP_SMALL_HIGH_LOW = 128'h66FFFFFF_FFFFFFFF_FFFFFFFF_FFFFFFAC;

    // whole table, map 0 in the lowest bits
    localparam logic [TABLE_W-1:0] DEFAULT_TABLE = {
        MAP_SMALL_HIGH_LOW, MAP_SMALL_HIGH_NONE, MAP_SMALL_LOW_HIGH, MAP_SMALL_LOW_NONE,
        MAP_LARGE_HIGH_LOW, MAP_LARGE_HIGH_NONE, MAP_LARGE_LOW_HIGH, MAP_LARGE_LOW_NONE
    };

endpackage

/* common/decode_if.sv */
`timescale 1ns/1ps
// lookup path between the decoder and its table
interface decode_if;
    logic [mem_decode_pkg::INDEX_W-1:0] index; // table address
    logic [mem_decode_pkg::ENTRY_W-1:0] entry; // nibble read out

    // the decoder asks, the table answers
    modport requester (output index, input entry);
    modport lookup (input index, output entry);
endinterface

/* verilog/input_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for a group of pin inputs
module input_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // pins in, safe levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("input_sync needs at least one bit");
    end

    // ------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : g_bit
        logic meta_ff; // first stage, read only by the second
        logic safe_ff; // second stage, the only one logic sees
        // both stages freeze with the clock enable
        always_ff @(posedge clk) begin
            if (srst) begin
                meta_ff <= RST_VAL[g];
                safe_ff <= RST_VAL[g];
            end else if (ce) begin
                meta_ff <= d[g];
                safe_ff <= meta_ff;
            end
        end
        assign q[g] = safe_ff;
    end

endmodule

/* verilog/decode_rom.sv */
`timescale 1ns/1ps
// fixed 256 x 4 decode table, replaceable by parameter
module decode_rom #(
    parameter logic [mem_decode_pkg::TABLE_W-1:0] TABLE_INIT = mem_decode_pkg::DEFAULT_TABLE
) (
    // index in, nibble out
    decode_if.lookup look
);

    // ------------------------------------------------------------
    // lookup
    // ------------------------------------------------------------
    // nibble position is index times four
    wire [9:0] bit_base = {look.index, 2'h0};
    assign look.entry = TABLE_INIT[bit_base +: mem_decode_pkg::ENTRY_W];

    // ------------------------------------------------------------
    // elaboration check of a substituted table
    // ------------------------------------------------------------
    // a select without the on-board flag would leave the buffers
    // facing the wrong way, so such a table is refused outright
    genvar g;
    for (g = 0; g < mem_decode_pkg::ENTRIES; g++) begin : g_chk
        localparam logic [3:0] NIB = TABLE_INIT[g*4 +: 4];
        if ((NIB[3:1] != 3'h7) && NIB[0]) begin : g_bad
            $error("decode table entry selects memory without on-board flag");
        end
    end

endmodule

/* verilog/memory_address_decoder.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// - table of 256 four-bit entries picks memory
// - top table bit low enables ram
// - ram two blocks, bank by A4
// - middle bits low enable eprom banks
// - flag bit low whenever any select low
// - flag low means on-board, steers buffers
// - nothing selected while memory enable inactive
// - five top address lines index blocks
// - three jumpers pick one of eight maps
// - jumpers: eprom size, ram place, eprom present
// - default table holds the standard maps
// - fixed index and output bit ordering
// - ram chip selects wait for strobes
// - normal placement: eprom low, ram high
// - alternate placement: ram low, eprom high
// - small parts in large setting alias
// - large setting routes A4 to eproms
// - deselect jumper removes all eprom selects
// - each eprom select drives two byte devices
// - blank entries select nothing, off-board
// ----------------------------------------------------------------
module memory_address_decoder #(
    parameter logic [mem_decode_pkg::TABLE_W-1:0] TABLE_INIT = mem_decode_pkg::DEFAULT_TABLE
) (
    // clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // processor memory bus
    input wire logic memory_cycle_enable_n,
    input wire logic write_strobe_n,
    input wire logic data_in_strobe,
    input wire logic [4:0] addr_block,
    // configuration jumpers
    input wire logic small_eprom_size,
    input wire logic ram_high_placement,
    input wire logic eprom_present,
    // raw table selects, active low
    output logic ram_select_out,
    output logic eprom_bank_b_select_out,
    output logic eprom_bank_a_select_out,
    output logic onboard_flag_out,
    // device selects, active low
    output logic [1:0] ram_bank_cs_n,
    output logic [1:0] eprom_bank_a_lane_cs_n,
    output logic [1:0] eprom_bank_b_lane_cs_n,
    // extra eprom address bit
    output logic eprom_extra_address
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    localparam int PIN_W = 11; // strobes, address, jumpers
    // memory enable and write strobe rest high, the rest low
    localparam logic [PIN_W-1:0] PIN_RST = 11'h003;

    logic [PIN_W-1:0] pins_raw; // pins as they arrive
    logic [PIN_W-1:0] pins_s; // pins after two stages

    assign pins_raw = {small_eprom_size, ram_high_placement, eprom_present,
                       addr_block, data_in_strobe, write_strobe_n,
                       memory_cycle_enable_n};

    // all pins share one synchroniser, so skew between bits
    // stays within one clock rather than growing per group
    input_sync #(
        .WIDTH(PIN_W),
        .RST_VAL(PIN_RST)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .d(pins_raw),
        .q(pins_s)
    );

    // named views of the synchronised pins
    wire memory_cycle_enable_n_n_s = pins_s[0]; // memory cycle enable, low active
    wire we_n_s = pins_s[1]; // write strobe, low active
    wire data_in_strobe_s = pins_s[2]; // read strobe, high active
    wire [4:0] addr_s = pins_s[7:3]; // A0..A4, A4 lowest
    wire present_s = pins_s[8]; // eprom present jumper
    wire ram_high_s = pins_s[9]; // ram placement jumper
    wire small_s = pins_s[10]; // eprom size jumper

    // ------------------------------------------------------------
    // table index and lookup
    // ------------------------------------------------------------
    decode_if dec (); // path to the table

    // the lowest index bit is the bank select address line
    wire bank_select_address_line = addr_s[0];
    wire table_index_lsb = bank_select_address_line;
    wire table_index_msb = small_s;

    // address lines low, jumpers high
    assign dec.index = {table_index_msb, ram_high_s, present_s,
                        addr_s[4:1], table_index_lsb};

    // default contents hold the eight standard maps; blank
    // entries are all ones, so they select nothing at all
    decode_rom #(
        .TABLE_INIT(TABLE_INIT)
    ) u_rom (
        .look(dec.lookup)
    );

    // ------------------------------------------------------------
    // select decode
    // ------------------------------------------------------------
    wire [3:0] entry = dec.entry; // nibble for this block
    wire cycle_act = ~memory_cycle_enable_n_n_s; // table enabled only in a cycle

    // ram enable straight from the top bit
    wire ram_n = ~(cycle_act & ~entry[mem_decode_pkg::RAM_BIT]);
    // eprom banks from the middle bits, killed by the jumper
    wire ep_b_n = ~(cycle_act & present_s
                    & ~entry[mem_decode_pkg::EPROM_B_BIT]);
    wire ep_a_n = ~(cycle_act & present_s
                    & ~entry[mem_decode_pkg::EPROM_A_BIT]);

    // flag follows the selects, not the table bit, so a select that the jumper
    // removed must not leave the buffers turned on-board
    wire any_sel = ~(ram_n & ep_b_n & ep_a_n); // some memory on board
    wire flag_n = ~(cycle_act & (~entry[mem_decode_pkg::ONBOARD_BIT] | any_sel)
                    & (any_sel | ~entry[mem_decode_pkg::ONBOARD_BIT]));
    wire flag_keep = flag_n | ~any_sel;
    wire nxt_flag = any_sel ? 1'h0 : flag_keep;

    // ram chips see a select only after the strobe is valid,
    // so fast parts never sample a write strobe still high
    wire strobe_ok = ~we_n_s | data_in_strobe_s;

    // ------------------------------------------------------------
    // per-bank ram selects
    // ------------------------------------------------------------
    logic [1:0] nxt_ram_cs_n; // next ram bank selects
    genvar b;
    for (b = 0; b < 2; b++) begin : g_ram_bank
        // bank picked by A4, gated by the strobes
        assign nxt_ram_cs_n[b] = ~(~ram_n & strobe_ok
                                   & (bank_select_address_line == 1'(b)));
    end

    // large devices take A4 as an extra address bit; small
    // devices ignore it, hence the alias at 0800 bytes
    wire nxt_extra = ~small_s & bank_select_address_line;

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // raw table selects
    always_ff @(posedge clk) begin
        if (srst) begin
            ram_select_out <= mem_decode_pkg::SELECT_IDLE;
            eprom_bank_b_select_out <= mem_decode_pkg::SELECT_IDLE;
            eprom_bank_a_select_out <= mem_decode_pkg::SELECT_IDLE;
            onboard_flag_out <= mem_decode_pkg::SELECT_IDLE;
        end else if (ce) begin
            ram_select_out <= ram_n;
            eprom_bank_b_select_out <= ep_b_n;
            eprom_bank_a_select_out <= ep_a_n;
            onboard_flag_out <= nxt_flag;
        end
    end

    // device selects and the extra address bit
    always_ff @(posedge clk) begin
        if (srst) begin
            ram_bank_cs_n <= {2{mem_decode_pkg::SELECT_IDLE}};
            eprom_bank_a_lane_cs_n <= {2{mem_decode_pkg::SELECT_IDLE}};
            eprom_bank_b_lane_cs_n <= {2{mem_decode_pkg::SELECT_IDLE}};
            eprom_extra_address <= mem_decode_pkg::EXTRA_ADDR_IDLE;
        end else if (ce) begin
            ram_bank_cs_n <= nxt_ram_cs_n;
            // low and high byte devices share a bank select
            eprom_bank_a_lane_cs_n <= {2{ep_a_n}};
            eprom_bank_b_lane_cs_n <= {2{ep_b_n}};
            eprom_extra_address <= nxt_extra;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // memory enable held inactive over the whole pin pipeline
    sequence seq_idle_held;
        (memory_cycle_enable_n && ce) [*3];
    endsequence

    // a decoded cycle seen in the previous clock
    sequence seq_cycle_seen;
        $past(ce) && !$past(memory_cycle_enable_n_n_s);
    endsequence

    // idle pin reaches the outputs three edges later
    AST_IDLE_PIN_CLEARS: assert property (
        seq_idle_held |=> (onboard_flag_out && ram_select_out && eprom_bank_a_select_out
                           && eprom_bank_b_select_out && (ram_bank_cs_n == 2'h3)))
        else $error("select active while memory enable held inactive");

    // synchronised idle gives idle outputs one edge later
    AST_IDLE_NO_SELECT: assert property (
        $past(ce) && $past(memory_cycle_enable_n_n_s) |-> onboard_flag_out && ram_select_out
                                           && eprom_bank_a_select_out && eprom_bank_b_select_out)
        else $error("select active outside a memory cycle");

    // ram enable follows the top table bit
    AST_RAM_FOLLOWS_TABLE: assert property (
        seq_cycle_seen |-> ram_select_out == $past(entry[3]))
        else $error("ram select differs from table bit");

    // bank a select follows its bit and the jumper
    AST_EPROM_A_TABLE: assert property (
        seq_cycle_seen |-> eprom_bank_a_select_out == ($past(entry[1]) | !$past(present_s)))
        else $error("eprom bank a select differs from table");

    // deselect jumper silences both eprom banks
    AST_NO_EPROM: assert property (
        $past(ce) && !$past(present_s) |-> eprom_bank_a_select_out && eprom_bank_b_select_out
                                            && (eprom_bank_a_lane_cs_n == 2'h3)
                                            && (eprom_bank_b_lane_cs_n == 2'h3))
        else $error("eprom selected while deselect jumper fitted");

    // any active select pulls the flag on-board
    AST_FLAG_OR: assert property (
        (!ram_select_out || !eprom_bank_a_select_out || !eprom_bank_b_select_out)
            |-> !onboard_flag_out)
        else $error("memory selected but flag says off-board");

    // a ram chip select needs a valid strobe behind it
    AST_RAM_STROBE: assert property (
        (ram_bank_cs_n != 2'h3) |-> (!$past(we_n_s) || $past(data_in_strobe_s)) && !ram_select_out)
        else $error("ram chip select without strobe");

    // bank 1 only when A4 was high, never both banks
    AST_RAM_BANK: assert property (
        !ram_bank_cs_n[1] |-> ram_bank_cs_n[0] && $past(bank_select_address_line))
        else $error("wrong ram bank selected");

    // extra address bit only in the large setting
    AST_EXTRA_ADDR: assert property (
        $past(ce) |-> eprom_extra_address == (!$past(small_s) && $past(bank_select_address_line)))
        else $error("extra eprom address bit wrong");

    // byte devices of a bank are always selected together
    AST_BYTE_LANES: assert property (
        (eprom_bank_a_lane_cs_n == {2{eprom_bank_a_select_out}})
        && (eprom_bank_b_lane_cs_n == {2{eprom_bank_b_select_out}}))
        else $error("eprom byte lanes split");

    // frozen clock enable holds the flag, the ram chip selects and the extra address bit
    AST_CE_FREEZE: assert property (
        !$past(ce) |-> $stable(onboard_flag_out) && $stable(ram_bank_cs_n)
                       && $stable(eprom_extra_address))
        else $error("outputs moved while clock enable low");

endmodule

/* test/cpu_bus_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// processor memory bus model, pins change on the falling edge
// ----------------------------------------------------------------
module cpu_bus_model (
    // clock
    input wire logic clk,
    // memory bus pins toward the decoder
    output logic memory_cycle_enable_n,
    output logic write_strobe_n,
    output logic data_in_strobe,
    output logic [4:0] addr_block,
    // decoder answer and off-board memory reply
    input wire logic onboard_flag_out,
    output logic offboard_respond
);
    // off-board memory keeps out of on-board ranges
    assign offboard_respond = ~memory_cycle_enable_n & onboard_flag_out;

    // idle bus at time zero
    initial begin
        memory_cycle_enable_n = 1'b1;
        write_strobe_n = 1'b1;
        data_in_strobe = 1'b0;
        addr_block = 5'h00;
    end

    // open a cycle: read strobe with the enable, write strobe later
    task automatic begin_cycle(input logic [4:0] blk, input logic wr);
        @(negedge clk);
        memory_cycle_enable_n = 1'b0;
        addr_block = blk;
        data_in_strobe = ~wr;
        write_strobe_n = 1'b1;
    endtask

    // late write strobe, as the processor gives it
    task automatic write_low;
        @(negedge clk);
        write_strobe_n = 1'b0;
    endtask

    // close a cycle; address lines show their inverse, never a stale value
    task automatic end_cycle;
        @(negedge clk);
        memory_cycle_enable_n = 1'b1;
        write_strobe_n = 1'b1;
        data_in_strobe = 1'b0;
        addr_block = ~addr_block;
    endtask
endmodule

/* test/memory_address_decoder_bench.sv */
`timescale 1ns/1ps
module memory_address_decoder_bench;
    // ------------------------------------------------------------
    // clock, reset and pins
    // ------------------------------------------------------------
    logic clk = 1'b0; // 25 MHz
    logic srst = 1'b1; // held for 8 cycles
    logic ce = 1'b1; // clock enable
    logic [2:0] jumpers = 3'h0; // {small, ram high, present}
    wire logic mem_en_n, wr_n, din, onb, ram_s, eb_s, ea_s, extra, offb;
    wire logic [4:0] blk;
    wire logic [1:0] ram_cs, a_cs, b_cs;
    // everything the decoder drives, in one vector
    wire logic [10:0] seen_pins = {ram_s, eb_s, ea_s, onb, ram_cs, a_cs, b_cs, extra};
    int errors = 0; // mismatches
    int checked = 0; // comparisons
    int cycles = 0; // timeout count

    initial begin
        forever #20 clk = ~clk;
    end

    memory_address_decoder dut (.clk(clk), .srst(srst), .ce(ce),
        .memory_cycle_enable_n(mem_en_n), .write_strobe_n(wr_n), .data_in_strobe(din),
        .addr_block(blk), .small_eprom_size(jumpers[2]), .ram_high_placement(jumpers[1]),
        .eprom_present(jumpers[0]), .ram_select_out(ram_s), .eprom_bank_b_select_out(eb_s),
        .eprom_bank_a_select_out(ea_s), .onboard_flag_out(onb), .ram_bank_cs_n(ram_cs),
        .eprom_bank_a_lane_cs_n(a_cs), .eprom_bank_b_lane_cs_n(b_cs),
        .eprom_extra_address(extra));

    cpu_bus_model cpu (.clk(clk), .memory_cycle_enable_n(mem_en_n), .write_strobe_n(wr_n),
        .data_in_strobe(din), .addr_block(blk), .onboard_flag_out(onb),
        .offboard_respond(offb));

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    // standard nibble of block i in map m
    function automatic logic [3:0] dflt(input logic [2:0] m, input logic [4:0] i);
        case (m)
            3'h0, 3'h4: dflt = (i < 5'h02) ? 4'h6 : 4'hF;
            3'h1: dflt = (i < 5'h02) ? 4'h6 : (i > 5'h1D) ? 4'hA : (i > 5'h1B) ? 4'hC : 4'hF;
            3'h2, 3'h6: dflt = (i > 5'h1D) ? 4'h6 : 4'hF;
            3'h3: dflt = (i < 5'h02) ? 4'hC : (i < 5'h04) ? 4'hA : (i > 5'h1D) ? 4'h6 : 4'hF;
            3'h5: dflt = (i < 5'h02) ? 4'h6 : (i == 5'h1E) ? 4'hC : (i == 5'h1F) ? 4'hA : 4'hF;
            default: dflt = (i == 5'h00) ? 4'hC : (i == 5'h01) ? 4'hA : (i > 5'h1D) ? 4'h6 : 4'hF;
        endcase
    endfunction

    // all pins for a cycle state; strb means the strobe has arrived
    function automatic logic [10:0] expect_pins(input logic [2:0] m, input logic [4:0] i,
            input logic act, input logic strb);
        logic [3:0] e;
        logic [1:0] rcs;
        e = act ? dflt(m, i) : 4'hF;
        rcs = 2'h3;
        // bank picked by the lowest address bit, only once strobed
        if (!e[3] && strb) rcs[i[0]] = 1'b0;
        expect_pins = {e, rcs, {2{e[1]}}, {2{e[2]}}, ~m[2] & i[0]};
    endfunction

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // three rising edges through the synchroniser, then sample settled
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic stop_test;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every block of every map read, then the bus idled
    task automatic sweep_maps;
        for (int m = 0; m < 8; m++) begin
            @(negedge clk);
            jumpers = m[2:0];
            for (int i = 0; i < 32; i++) begin
                cpu.begin_cycle(i[4:0], 1'b0);
                settle();
                check(seen_pins, expect_pins(m[2:0], i[4:0], 1'b1, 1'b1));
                // off-board memory answers only where the table says off-board
                check({10'h000, offb}, 11'(dflt(m[2:0], i[4:0]) & 4'h1));
                cpu.end_cycle();
                settle();
                check(seen_pins, expect_pins(m[2:0], ~i[4:0], 1'b0, 1'b0));
                check({10'h000, offb}, 11'h000);
            end
        end
    endtask

    // ram chip selects wait for the late write strobe, both banks
    task automatic write_gate;
        @(negedge clk);
        jumpers = 3'h7;
        for (int i = 30; i < 32; i++) begin
            cpu.begin_cycle(i[4:0], 1'b1);
            settle();
            check(seen_pins, expect_pins(3'h7, i[4:0], 1'b1, 1'b0));
            cpu.write_low();
            settle();
            check(seen_pins, expect_pins(3'h7, i[4:0], 1'b1, 1'b1));
            cpu.end_cycle();
            settle();
        end
    endtask

    // clock enable low freezes the selects
    task automatic freeze;
        cpu.begin_cycle(5'h00, 1'b0);
        settle();
        @(negedge clk);
        ce = 1'b0;
        cpu.end_cycle();
        settle();
        check(seen_pins, expect_pins(3'h7, 5'h00, 1'b1, 1'b1));
        @(negedge clk);
        ce = 1'b1;
        settle();
        check(seen_pins, expect_pins(3'h7, 5'h1F, 1'b0, 1'b0));
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(seen_pins, 11'h7FE);
        srst = 1'b0;
        sweep_maps();
        write_gate();
        freeze();
        stop_test();
    end

    // the whole run needs about 2100 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            stop_test();
        end
    end
endmodule
